// ---- rtl/spr_pkg.sv ----
// Constants shared by the serial port receiver
package spr_pkg;
    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_FLAGS_1   = 8'h0C;
    localparam logic [7:0] ADDR_RX_STATUS = 8'h18;
    localparam logic [7:0] ADDR_RX_DATA   = 8'h1A;
    localparam logic [7:0] ADDR_ENABLES_1 = 8'h8C;
    localparam logic [7:0] ADDR_TX_STATUS = 8'h98;
    localparam logic [7:0] ADDR_BAUD_DIV  = 8'h99;
    // Receive status/control fields
    localparam int RS_SERIAL_PORT_ENABLE  = 7;
    localparam int RS_RX9   = 6;
    localparam int RS_SINGLE_RECEIVE_ENABLE  = 5;
    localparam int RS_CONTINUOUS_RECEIVE_ENABLE  = 4;
    localparam int RS_ADDRESS_DETECT_ENABLE = 3;
    localparam int RS_FRAMING_ERROR  = 2;
    localparam int RS_OVERRUN_ERROR  = 1;
    localparam int RS_RECEIVED_NINTH_BIT  = 0;
    // Flag / enable bit positions
    localparam int FL_RCV   = 5;
    // Transmit status/control fields
    localparam int TS_MASTER_CLOCK_SOURCE  = 7;
    localparam int TS_SYNC  = 4;
    localparam int TS_HIGH_BAUD_SELECT  = 2;
    localparam int TS_TRMT  = 1;
    // Reset values
    localparam logic [7:0] RST_TX_STATUS = 8'h02;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    // Writable masks
    localparam logic [7:0] MASK_RX_STATUS_W = 8'hF8;
    localparam logic [7:0] MASK_TX_STATUS_W = 8'hF5;
    // Baud prescale: low range divides by 64, high range by 16, sync master by 4
    localparam logic [5:0] PRE_LOW  = 6'h3F;
    localparam logic [5:0] PRE_HIGH = 6'h0F;
    localparam logic [5:0] PRE_SYNC = 6'h03;
    // Async oversampling per bit in ticks
    localparam logic [3:0] OVS_LAST = 4'hF;
    localparam logic [3:0] OVS_MID  = 4'h7;
endpackage : spr_pkg

// ---- rtl/spr_sync.sv ----
// Two-flop synchroniser for one level from another domain
`timescale 1ns/1ps
module spr_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Level in and out
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    // First flop feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b1;
            q      <= 1'b1;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : spr_sync

// ---- rtl/spr_receiver.sv ----
// Serial port receiver: async 9-bit with address detect and sync master receive
// Operation
// - Sync master mode starts receiving when single or continuous enable is set
// - Sync master samples data pin on falling serial clock edge
// - In sync master mode single enable alone captures exactly one word, then stops
// - Continuous enable receives words back to back until cleared
// - Both enables set behaves as continuous mode
// - Last bit moves shift register into FIFO when room exists
// - Move sets receive flag; interrupt only while irq enable set
// - Receive flag read-only, cleared when FIFO read empty
// - Receive data is a two-entry FIFO read oldest first
// - Full FIFO at third word's end sets overrun, word discarded
// - Overrun set blocks all moves into the FIFO
// - Overrun clears only when software clears continuous enable
// - Ninth bit queued with word; read updates ninth-bit status
// - Address detect clear lets all bytes in with a flag each
// - High baud select switches generator to high-speed range in async mode
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module spr_receiver (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Serial data pin
    input  wire logic       rx_data_pin,
    // Serial clock pin, two-way
    input  wire logic       sclk_in,
    output logic            sclk_out,
    output logic            sclk_oe_b,
    // Interrupt request
    output logic            rx_irq
);
    typedef enum logic [1:0] {SPR_IDLE, SPR_START, SPR_DATA, SPR_STOP} spr_state_t;

    logic [7:0] rx_status_r, tx_status_r, baud_div_r, enables_r;
    logic       framing_error_r, overrun_error_r, received_ninth_bit_r;
    logic [7:0] fifo_data_r [2];
    logic       fifo_b9_r   [2];
    logic [1:0] fifo_cnt_r;
    logic       rd_ptr_r, wr_ptr_r;
    logic [8:0] shift_r;
    logic [3:0] bit_cnt_r, ovs_r;
    logic [5:0] pre_r;
    logic [7:0] brg_r;
    logic       tick;
    spr_state_t st_r;
    logic       din_s, sclk_s, sclk_d_r, word_done, word_b9, word_stop_ok;
    logic [7:0] word_data;
    logic       sync_mode, continuous_receive_enable, single_receive_enable, serial_port_enable, rx9, address_detect_enable, master;

    assign sync_mode = tx_status_r[spr_pkg::TS_SYNC];
    assign master    = tx_status_r[spr_pkg::TS_MASTER_CLOCK_SOURCE];
    assign serial_port_enable      = rx_status_r[spr_pkg::RS_SERIAL_PORT_ENABLE];
    assign rx9       = rx_status_r[spr_pkg::RS_RX9];
    assign single_receive_enable      = rx_status_r[spr_pkg::RS_SINGLE_RECEIVE_ENABLE];
    assign continuous_receive_enable      = rx_status_r[spr_pkg::RS_CONTINUOUS_RECEIVE_ENABLE];
    assign address_detect_enable     = rx_status_r[spr_pkg::RS_ADDRESS_DETECT_ENABLE];

    // Pin synchronisers
    spr_sync u_sync_din (.clk(clk), .rst_b(rst_b), .d(rx_data_pin), .q(din_s));
    spr_sync u_sync_clk (.clk(clk), .rst_b(rst_b), .d(sclk_in), .q(sclk_s));

    function automatic logic is_rd(input logic [7:0] a);
        is_rd = reg_rd && (reg_addr == a);
    endfunction : is_rd

    function automatic logic is_wr(input logic [7:0] a);
        is_wr = reg_wr && (reg_addr == a);
    endfunction : is_wr

    logic fifo_pop, fifo_push, overrun_hit;
    assign fifo_pop = is_rd(spr_pkg::ADDR_RX_DATA) && (fifo_cnt_r != 2'h0);
    // Address detect drops async nine-bit words whose ninth bit is clear
    assign fifo_push = word_done && !overrun_error_r && (fifo_cnt_r != 2'h2)
                       && !(address_detect_enable && rx9 && !sync_mode && !word_b9);
    assign overrun_hit = word_done && !overrun_error_r && (fifo_cnt_r == 2'h2);

    // Control registers written by software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_status_r <= spr_pkg::RST_ZERO;
            tx_status_r <= spr_pkg::RST_TX_STATUS;
            baud_div_r  <= spr_pkg::RST_ZERO;
            enables_r   <= spr_pkg::RST_ZERO;
        end else begin
            if (is_wr(spr_pkg::ADDR_RX_STATUS))
                rx_status_r <= reg_wdata & spr_pkg::MASK_RX_STATUS_W;
            else if (sync_mode && word_done && !continuous_receive_enable)
                rx_status_r[spr_pkg::RS_SINGLE_RECEIVE_ENABLE] <= 1'b0;
            if (is_wr(spr_pkg::ADDR_TX_STATUS))
                tx_status_r <= (reg_wdata & spr_pkg::MASK_TX_STATUS_W) | spr_pkg::RST_TX_STATUS;
            if (is_wr(spr_pkg::ADDR_BAUD_DIV))
                baud_div_r <= reg_wdata;
            if (is_wr(spr_pkg::ADDR_ENABLES_1))
                enables_r <= reg_wdata;
        end
    end

    // Baud generator: prescale then divisor reload
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= 6'h00;
            brg_r <= 8'h00;
            tick  <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (pre_r == 6'h00) begin
                // High range shortens the prescale four times; sync master is faster still
                if (sync_mode)
                    pre_r <= spr_pkg::PRE_SYNC;
                else if (tx_status_r[spr_pkg::TS_HIGH_BAUD_SELECT])
                    pre_r <= spr_pkg::PRE_HIGH;
                else
                    pre_r <= spr_pkg::PRE_LOW;
                if (brg_r == 8'h00) begin
                    brg_r <= baud_div_r;
                    tick  <= 1'b1;
                end else begin
                    brg_r <= brg_r - 8'h01;
                end
            end else begin
                pre_r <= pre_r - 6'h01;
            end
        end
    end

    logic rx_enable;
    assign rx_enable = serial_port_enable && (continuous_receive_enable || single_receive_enable);

    // Receive state machine for both modes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r         <= SPR_IDLE;
            shift_r      <= 9'h000;
            bit_cnt_r    <= 4'h0;
            ovs_r        <= 4'h0;
            sclk_out     <= 1'b1;
            sclk_d_r     <= 1'b1;
            word_done    <= 1'b0;
            word_data    <= 8'h00;
            word_b9      <= 1'b0;
            word_stop_ok <= 1'b1;
        end else begin
            word_done <= 1'b0;
            sclk_d_r  <= sclk_s;
            case (st_r)
                SPR_IDLE: begin
                    sclk_out  <= 1'b1;
                    bit_cnt_r <= 4'h0;
                    ovs_r     <= 4'h0;
                    // Wait out the done cycle so a single word cannot restart
                    if (rx_enable && sync_mode && master && !overrun_error_r && !word_done)
                        st_r <= SPR_DATA;
                    else if (serial_port_enable && continuous_receive_enable && !sync_mode && !din_s)
                        st_r <= SPR_START;
                end
                SPR_START: begin
                    if (tick) begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == spr_pkg::OVS_MID && din_s)
                            st_r <= SPR_IDLE; // Glitch, not a start bit
                        else if (ovs_r == spr_pkg::OVS_LAST)
                            st_r <= SPR_DATA;
                    end
                end
                SPR_DATA: begin
                    if (sync_mode) begin
                        // Clock toggles on each tick; high then low is one bit
                        if (tick)
                            sclk_out <= ~sclk_out;
                        if (sclk_d_r && !sclk_s) begin
                            shift_r   <= {din_s, shift_r[8:1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == (rx9 ? 4'h8 : 4'h7)) begin
                                word_done <= 1'b1;
                                word_data <= rx9 ? shift_r[8:1] : {din_s, shift_r[8:2]};
                                word_b9   <= rx9 ? din_s : 1'b0;
                                bit_cnt_r <= 4'h0;
                                // Continuous keeps going; single stops here
                                if (!continuous_receive_enable)
                                    st_r <= SPR_IDLE;
                            end
                        end
                        if (!rx_enable || !serial_port_enable)
                            st_r <= SPR_IDLE;
                    end else if (tick) begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == spr_pkg::OVS_MID) begin
                            shift_r   <= {din_s, shift_r[8:1]};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (bit_cnt_r == (rx9 ? 4'h8 : 4'h7))
                                st_r <= SPR_STOP;
                        end
                    end
                end
                SPR_STOP: begin
                    if (tick) begin
                        ovs_r <= ovs_r + 4'h1;
                        if (ovs_r == spr_pkg::OVS_MID) begin
                            word_done    <= 1'b1;
                            word_data    <= rx9 ? shift_r[7:0] : shift_r[8:1];
                            word_b9      <= rx9 ? shift_r[8] : 1'b0;
                            word_stop_ok <= din_s;
                            st_r         <= SPR_IDLE;
                        end
                    end
                end
                default: st_r <= SPR_IDLE;
            endcase
        end
    end

    // Error bits: overrun sticks until continuous enable is written clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overrun_error_r <= 1'b0;
            framing_error_r <= 1'b0;
        end else begin
            if (overrun_hit)
                overrun_error_r <= 1'b1;
            else if (is_wr(spr_pkg::ADDR_RX_STATUS) && !reg_wdata[spr_pkg::RS_CONTINUOUS_RECEIVE_ENABLE])
                overrun_error_r <= 1'b0;
            if (fifo_push)
                framing_error_r <= !word_stop_ok;
        end
    end

    // Two-entry FIFO with ninth bit alongside
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_cnt_r     <= 2'h0;
            rd_ptr_r       <= 1'b0;
            wr_ptr_r       <= 1'b0;
            fifo_data_r[0] <= 8'h00;
            fifo_data_r[1] <= 8'h00;
            fifo_b9_r[0]   <= 1'b0;
            fifo_b9_r[1]   <= 1'b0;
        end else begin
            if (fifo_push) begin
                fifo_data_r[wr_ptr_r] <= word_data;
                fifo_b9_r[wr_ptr_r]   <= word_b9;
                wr_ptr_r              <= ~wr_ptr_r;
            end
            if (fifo_pop)
                rd_ptr_r <= ~rd_ptr_r;
            fifo_cnt_r <= fifo_cnt_r + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // Ninth-bit status shows the head entry
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            received_ninth_bit_r <= 1'b0;
        else if (fifo_cnt_r == 2'h0 && fifo_push)
            received_ninth_bit_r <= word_b9;
        else if (fifo_pop && fifo_cnt_r == 2'h2)
            received_ninth_bit_r <= fifo_b9_r[~rd_ptr_r];
        else if (fifo_pop && fifo_push)
            received_ninth_bit_r <= word_b9;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                spr_pkg::ADDR_FLAGS_1:   reg_rdata <= {2'b00, (fifo_cnt_r != 2'h0), 5'h00};
                spr_pkg::ADDR_RX_STATUS: reg_rdata <= {rx_status_r[7:3], framing_error_r, overrun_error_r, received_ninth_bit_r};
                spr_pkg::ADDR_RX_DATA:   reg_rdata <= fifo_data_r[rd_ptr_r];
                spr_pkg::ADDR_ENABLES_1: reg_rdata <= enables_r;
                spr_pkg::ADDR_TX_STATUS: reg_rdata <= tx_status_r;
                spr_pkg::ADDR_BAUD_DIV:  reg_rdata <= baud_div_r;
                default:                 reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Clock pin output enable and interrupt, both registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_oe_b <= 1'b1;
            rx_irq    <= 1'b0;
        end else begin
            sclk_oe_b <= !(serial_port_enable && sync_mode && master);
            // Flag follows FIFO occupancy; set wins since push raises count
            rx_irq <= ((fifo_cnt_r != 2'h0) || fifo_push) && enables_r[spr_pkg::FL_RCV];
        end
    end

    a_flag_irq: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_push && enables_r[spr_pkg::FL_RCV] |=> rx_irq)
        else $error("irq missing after push");
    a_ovr_sets: assert property (@(posedge clk) disable iff (!rst_b)
        overrun_hit |=> overrun_error_r && fifo_cnt_r == $past(fifo_cnt_r) - {1'b0, $past(fifo_pop)})
        else $error("overrun not flagged");
    a_ovr_blocks: assert property (@(posedge clk) disable iff (!rst_b)
        overrun_error_r |-> !fifo_push)
        else $error("push during overrun");
    a_ovr_clear: assert property (@(posedge clk) disable iff (!rst_b)
        overrun_error_r && !overrun_hit && !(is_wr(spr_pkg::ADDR_RX_STATUS)
        && !reg_wdata[spr_pkg::RS_CONTINUOUS_RECEIVE_ENABLE]) |=> overrun_error_r)
        else $error("overrun cleared by itself");
    a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_cnt_r <= 2'h2)
        else $error("fifo count over two");
    a_flag_drop: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_cnt_r == 2'h1 && fifo_pop && !fifo_push |=> fifo_cnt_r == 2'h0)
        else $error("flag not cleared on empty");
    a_single_stop: assert property (@(posedge clk) disable iff (!rst_b)
        sync_mode && word_done && !$past(continuous_receive_enable) && !reg_wr |-> st_r == SPR_IDLE)
        else $error("single receive kept going");
    a_brg_tick: assert property (@(posedge clk) disable iff (!rst_b)
        tick |-> $past(pre_r) == 6'h00)
        else $error("tick without prescale end");
    a_brg_range: assert property (@(posedge clk) disable iff (!rst_b)
        pre_r == 6'h00 && !sync_mode && tx_status_r[spr_pkg::TS_HIGH_BAUD_SELECT] |=> pre_r == spr_pkg::PRE_HIGH)
        else $error("high range prescale not used");
    a_received_ninth_bit_head: assert property (@(posedge clk) disable iff (!rst_b)
        fifo_cnt_r != 2'h0 |-> received_ninth_bit_r == fifo_b9_r[rd_ptr_r])
        else $error("ninth bit not of head entry");
    a_fall_sample: assert property (@(posedge clk) disable iff (!rst_b)
        sync_mode && st_r == SPR_DATA && !(sclk_d_r && !sclk_s) |=> $stable(shift_r))
        else $error("shift without falling clock");
    // Single receive: word finishes while continuous enable is clear
    sequence s_single_done;
        sync_mode && word_done && !continuous_receive_enable && !is_wr(spr_pkg::ADDR_RX_STATUS);
    endsequence
    a_single_receive_enable_clear: assert property (@(posedge clk) disable iff (!rst_b)
        s_single_done |=> !single_receive_enable)
        else $error("single enable not cleared");
endmodule : spr_receiver

// ---- tb/spr_station.sv ----
// Remote serial station model: shifts queued words onto the data line
`timescale 1ns/1ps
module spr_station (
    // Serial clock as seen on the wire
    input  wire logic sclk_wire,
    // Data line towards the receiver
    output logic      data_out,
    // Falling clock edges seen so far
    output int        fall_count
);
    logic bits_q[$];
    logic last_bit;
    logic fell;

    initial begin
        last_bit   = 1'b0;
        fell       = 1'b0;
        fall_count = 0;
        data_out   = 1'b1;
    end

    // Queue a word, LSB first
    task automatic load(input logic [8:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            bits_q.push_back(w[i]);
        end
        data_out = bits_q[0];
    endtask : load

    // Line at its idle level before an async frame
    task automatic line_idle();
        data_out = 1'b1;
    endtask : line_idle

    // Async frame: start, n bits LSB first, stop, one idle bit
    task automatic send_async(input logic [8:0] w, input int n, input logic stop_ok,
                              input int bit_ns);
        data_out = 1'b0;
        #(bit_ns);
        for (int i = 0; i < n; i++) begin
            data_out = w[i];
            #(bit_ns);
        end
        // A broken stop is low only past its middle, so no false start follows
        data_out = stop_ok;
        #(bit_ns * 5 / 8);
        data_out = 1'b1;
        #(bit_ns * 3 / 8 + bit_ns);
    endtask : send_async

    // Count edges; the receiver samples here
    always @(negedge sclk_wire) begin
        fall_count++;
        fell = 1'b1;
    end

    // Change data only on the rising edge so it is stable at the fall
    always @(posedge sclk_wire) begin
        if (fell) begin
            fell = 1'b0;
            if (bits_q.size() != 0) begin
                last_bit = bits_q.pop_front();
            end
            // Released line shows the inverse, not a held value
            data_out = (bits_q.size() != 0) ? bits_q[0] : ~last_bit;
        end
    end
endmodule : spr_station

// ---- tb/spr_receiver_tb.sv ----
// Self-checking bench for the serial port receiver in sync master and async modes
`timescale 1ns/1ps
module spr_receiver_tb;
    localparam logic [7:0] B_SERIAL_PORT_ENABLE = 8'h01 << spr_pkg::RS_SERIAL_PORT_ENABLE;
    localparam logic [7:0] B_RX9  = 8'h01 << spr_pkg::RS_RX9;
    localparam logic [7:0] B_SINGLE_RECEIVE_ENABLE = 8'h01 << spr_pkg::RS_SINGLE_RECEIVE_ENABLE;
    localparam logic [7:0] B_CONTINUOUS_RECEIVE_ENABLE = 8'h01 << spr_pkg::RS_CONTINUOUS_RECEIVE_ENABLE;
    localparam logic [7:0] B_OVERRUN_ERROR = 8'h01 << spr_pkg::RS_OVERRUN_ERROR;
    localparam logic [7:0] B_FLAG = 8'h01 << spr_pkg::FL_RCV;
    localparam logic [7:0] B_ADDRESS_DETECT_ENABLE = 8'h01 << spr_pkg::RS_ADDRESS_DETECT_ENABLE;
    // Async bit time in ns: high range, divisor zero, 16 ticks a bit
    localparam int BIT_NS = 40 * (spr_pkg::PRE_HIGH + 1) * (spr_pkg::OVS_LAST + 1);
    logic       clk;
    logic       rst_b;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       rx_data_pin;
    logic       sclk_wire;
    logic       sclk_out;
    logic       sclk_oe_b;
    logic       rx_irq;
    int         fall_count;
    int         bad_count;
    int         check_count;
    logic [7:0] v;
    int         base;

    // Clock pin has a pull-up; the device drives it only when enabled
    assign sclk_wire = sclk_oe_b ? 1'b1 : sclk_out;

    spr_receiver spr_receiver_inst (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_data_pin(rx_data_pin), .sclk_in(sclk_wire), .sclk_out(sclk_out),
        .sclk_oe_b(sclk_oe_b), .rx_irq(rx_irq)
    );

    spr_station spr_station_inst (
        .sclk_wire(sclk_wire), .data_out(rx_data_pin), .fall_count(fall_count)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // Data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Bounded wait for n falling serial clock edges after base
    task automatic wait_falls(input int n);
        int k;
        for (k = 0; k < 20000 && fall_count < base + n; k++) begin
            @(posedge clk);
        end
        if (k == 20000) begin
            check(k, 0, "serial clock wait");
            complete_run();
        end
        repeat (8) @(posedge clk);
    endtask : wait_falls

    // Reset values, unmapped address and read-only bits
    task automatic t_regs();
        logic [7:0] at[7] = '{8'h0C, 8'h18, 8'h1A, 8'h8C, 8'h98, 8'h99, 8'h55};
        logic [7:0] et[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            reg_read(at[i], v);
            check(v, et[i], "reset value");
        end
        check(sclk_oe_b, 1'b1, "clock pin released");
        reg_write(8'h99, 8'h5A);
        reg_read(8'h99, v);
        check(v, 8'h5A, "baud divisor");
        reg_write(8'h18, 8'h1F);
        reg_read(8'h18, v);
        check(v, 8'h18, "status read-only bits");
        reg_write(8'h0C, 8'hFF);
        reg_read(8'h0C, v);
        check(v, 8'h00, "flag not writable");
        reg_write(8'h18, 8'h00);
    endtask : t_regs

    // Sync master set-up with both enables clear
    task automatic sync_setup();
        reg_write(8'h99, 8'h00);
        reg_write(8'h98, 8'h94);
        reg_write(8'h18, B_SERIAL_PORT_ENABLE);
        base = fall_count;
        repeat (100) @(posedge clk);
        check(sclk_oe_b, 1'b0, "clock pin driven");
        check(fall_count, base, "no clock before enable");
    endtask : sync_setup

    // Single word with interrupt enabled
    task automatic t_single();
        reg_write(8'h8C, B_FLAG);
        spr_station_inst.load(9'h0A5, 8);
        base = fall_count;
        reg_write(8'h18, B_SERIAL_PORT_ENABLE | B_SINGLE_RECEIVE_ENABLE);
        wait_falls(8);
        check(rx_irq, 1'b1, "interrupt raised");
        repeat (300) @(posedge clk);
        check(fall_count, base + 8, "one word then stop");
        reg_read(8'h18, v);
        check(v & (B_SINGLE_RECEIVE_ENABLE | B_CONTINUOUS_RECEIVE_ENABLE), 8'h00, "single enable cleared");
        reg_read(8'h0C, v);
        check(v, B_FLAG, "flag set");
        reg_read(8'h1A, v);
        check(v, 8'hA5, "word moved");
        reg_read(8'h0C, v);
        check(v, 8'h00, "flag cleared when empty");
        check(rx_irq, 1'b0, "interrupt dropped");
    endtask : t_single

    // Both enables, 9-bit, three words into a two-deep FIFO
    task automatic t_overrun();
        reg_write(8'h8C, 8'h00);
        spr_station_inst.load(9'h13C, 9);
        spr_station_inst.load(9'h0C3, 9);
        spr_station_inst.load(9'h155, 9);
        base = fall_count;
        reg_write(8'h18, B_SERIAL_PORT_ENABLE | B_RX9 | B_SINGLE_RECEIVE_ENABLE | B_CONTINUOUS_RECEIVE_ENABLE);
        wait_falls(27);
        check(rx_irq, 1'b0, "interrupt masked");
        wait_falls(36);
        base = fall_count;
        repeat (40) @(posedge clk);
        check(fall_count > base, 1'b1, "continuous clocking");
        reg_read(8'h18, v);
        check(v & 8'hD3, 8'hD3, "overrun set, ninth bit of head");
        reg_read(8'h1A, v);
        check(v, 8'h3C, "oldest first");
        reg_read(8'h18, v);
        check(v[0], 1'b0, "ninth bit follows pop");
        reg_read(8'h1A, v);
        check(v, 8'hC3, "second word, third lost");
        reg_read(8'h0C, v);
        check(v, 8'h00, "moves blocked");
        reg_write(8'h18, B_SERIAL_PORT_ENABLE | B_RX9);
        reg_read(8'h18, v);
        check(v & B_OVERRUN_ERROR, 8'h00, "overrun cleared");
    endtask : t_overrun

    // Async 9-bit reception with address detect, high baud range
    task automatic t_async();
        reg_write(8'h99, 8'h00);
        reg_write(8'h98, 8'h04);
        reg_write(8'h18, B_SERIAL_PORT_ENABLE);
        reg_write(8'h8C, B_FLAG);
        reg_write(8'h18, B_SERIAL_PORT_ENABLE | B_RX9 | B_ADDRESS_DETECT_ENABLE);
        spr_station_inst.line_idle();
        reg_write(8'h18, B_SERIAL_PORT_ENABLE | B_RX9 | B_ADDRESS_DETECT_ENABLE | B_CONTINUOUS_RECEIVE_ENABLE);
        spr_station_inst.send_async(9'h012, 9, 1'b1, BIT_NS);
        reg_read(8'h0C, v);
        check(v, 8'h00, "data byte skipped");
        check(rx_irq, 1'b0, "no interrupt for skipped byte");
        spr_station_inst.send_async(9'h1B4, 9, 1'b0, BIT_NS);
        repeat (16) @(posedge clk);
        check(rx_irq, 1'b1, "address byte interrupt");
        reg_read(8'h18, v);
        check(v & 8'h05, 8'h05, "ninth bit and framing error");
        reg_read(8'h1A, v);
        check(v, 8'hB4, "address byte");
        reg_write(8'h18, B_SERIAL_PORT_ENABLE | B_RX9 | B_CONTINUOUS_RECEIVE_ENABLE);
        spr_station_inst.send_async(9'h06D, 9, 1'b1, BIT_NS);
        repeat (16) @(posedge clk);
        reg_read(8'h18, v);
        check(v & 8'h05, 8'h00, "data byte, good stop");
        reg_read(8'h1A, v);
        check(v, 8'h6D, "data byte accepted");
    endtask : t_async

    initial begin
        bad_count   = 0;
        check_count = 0;
        rst_b       = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        sync_setup();
        t_single();
        t_overrun();
        t_async();
        complete_run();
    end
endmodule : spr_receiver_tb
